// ===== wlc_pkg.sv
// package for the warning latch and clear block
package wlc_pkg;
  localparam int NUM_WARN = 10;
  localparam int CLK_HZ = 50000000;
  // warning bit positions, bit n carries code An
  localparam int W_OVERLOAD = 0;
  localparam int W_REGEN = 1;
  localparam int W_BATTERY = 2;
  localparam int W_FAN = 3;
  localparam int W_ENC_COMM = 4;
  localparam int W_ENC_HEAT = 5;
  localparam int W_OSC = 6;
  localparam int W_LIFE = 7;
  localparam int W_SCALE_ERR = 8;
  localparam int W_SCALE_COMM = 9;
  // load factor threshold in percent of protection level
  localparam int LOAD_WARN_PCT = 85;
  // battery threshold in millivolts
  localparam int BATT_WARN_MV = 3200;
  localparam int FAN_STOP_MS = 1000;
  localparam int CLR_MIN_MS = 120;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int FAN_STOP_CYCLES = FAN_STOP_MS * MS_CYCLES;
  // strictly longer than 120 ms
  localparam int CLR_MIN_CYCLES = CLR_MIN_MS * MS_CYCLES + 1;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam logic [3:0] HOLD_MIN_S = 4'h1;
  localparam logic [3:0] HOLD_MAX_S = 4'ha;
  // hold code 0 means hold until cleared
  localparam logic [3:0] HOLD_INF = 4'h0;
  // wishbone register byte addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_ACTIVE = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_ID = 8'h14;
  // config field positions
  localparam int CFG_HOLD_LSB = 0;
  localparam int CFG_ENC_LIM_LSB = 8;
  localparam int CFG_SCL_LIM_LSB = 16;
  localparam logic [3:0] HOLD_RST = 4'h0;
  localparam logic [7:0] ENC_LIM_RST = 8'h03;
  localparam logic [7:0] SCL_LIM_RST = 8'h03;
  localparam int CTRL_CLEAR_BIT = 0;
  // front panel list cursor
  typedef struct packed {
    logic key_up;
    logic key_down;
  } wlc_keys_s;
  typedef struct packed {
    logic overload_pct_ge;
    logic regen_pct_ge;
    logic batt_low;
    logic fan_stopped;
    logic enc_comm_err;
    logic enc_comm_ok;
    logic enc_overheat;
    logic osc_detect;
    logic life_short;
    logic scale_alarm;
    logic scale_comm_err;
    logic scale_comm_ok;
  } wlc_cond_s;
endpackage

// ===== wlc_warning_latch.sv
// warning latch, hold timers, clear logic and wishbone registers
`timescale 1ns/1ns
module wlc_warning_latch #(
  parameter int FAN_STOP_CYC = wlc_pkg::FAN_STOP_CYCLES,
  parameter int CLR_MIN_CYC = wlc_pkg::CLR_MIN_CYCLES,
  parameter int SEC_CYC = wlc_pkg::SEC_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire wlc_pkg::wlc_cond_s cond,
  input wire logic warning_clear_input,
  input wire logic panel_clear_cmd,
  input wire wlc_pkg::wlc_keys_s keys,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [9:0] warn_active,
  output logic [3:0] panel_code,
  output logic panel_valid,
  output logic irq
);
  localparam int NW = wlc_pkg::NUM_WARN;
  localparam logic [31:0] ID_VALUE = 32'h00005a01; // arbitrary value

  // pin inputs pass two flops before use
  logic [1:0] clr_sync_q;
  logic clr_pin;
  assign clr_pin = clr_sync_q[1];

  logic [9:0] raw;
  logic [9:0] warn_q;
  logic [9:0] sticky_q;
  logic [9:0] mask_q;
  logic [3:0] hold_q;
  logic [7:0] enc_lim_q;
  logic [7:0] scl_lim_q;
  logic sw_clear_q;
  logic [31:0] fan_cnt_q;
  logic [31:0] clr_cnt_q;
  logic [7:0] enc_cnt_q;
  logic [7:0] scl_cnt_q;
  logic [31:0] sec_cnt_q;
  logic sec_tick;
  logic [3:0] hold_left_q [NW];
  logic [3:0] cursor_q;
  logic [1:0] key_q;
  logic [1:0] key_sync_q [2];
  logic [31:0] wb_dat_q;
  logic ack_q;
  logic irq_q;

  // condition detection
  logic fan_long;
  logic clr_long;
  assign fan_long = fan_cnt_q >= 32'(FAN_STOP_CYC);
  assign clr_long = clr_cnt_q >= 32'(CLR_MIN_CYC);
  assign raw[wlc_pkg::W_OVERLOAD] = cond.overload_pct_ge;
  assign raw[wlc_pkg::W_REGEN] = cond.regen_pct_ge;
  assign raw[wlc_pkg::W_BATTERY] = cond.batt_low;
  assign raw[wlc_pkg::W_FAN] = fan_long;
  assign raw[wlc_pkg::W_ENC_COMM] = enc_cnt_q > enc_lim_q;
  assign raw[wlc_pkg::W_ENC_HEAT] = cond.enc_overheat;
  assign raw[wlc_pkg::W_OSC] = cond.osc_detect;
  assign raw[wlc_pkg::W_LIFE] = cond.life_short;
  assign raw[wlc_pkg::W_SCALE_ERR] = cond.scale_alarm;
  assign raw[wlc_pkg::W_SCALE_COMM] = scl_cnt_q > scl_lim_q;

  // any clear source forces every warning low and blocks re-raise;
  // a level cause that is still present comes back once it ends
  logic clear_any;
  assign clear_any = clr_pin | panel_clear_cmd | sw_clear_q;

  logic infinite;
  assign infinite = hold_q == wlc_pkg::HOLD_INF;
  assign sec_tick = sec_cnt_q == 32'(SEC_CYC - 1);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clr_sync_q <= 2'h0;
      key_sync_q[0] <= 2'h0;
      key_sync_q[1] <= 2'h0;
    end
    else if (clk_en)
    begin
      clr_sync_q <= {clr_sync_q[0], warning_clear_input};
      key_sync_q[0] <= {keys.key_up, keys.key_down};
      key_sync_q[1] <= key_sync_q[0];
    end
  end

  // fan stop must be continuous; any running sample restarts the count
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fan_cnt_q <= 32'h0;
    else if (clk_en)
    begin
      if (!cond.fan_stopped)
        fan_cnt_q <= 32'h0;
      else if (!fan_long)
        fan_cnt_q <= fan_cnt_q + 32'h1;
    end
  end

  // measures the pin clear; saturates so a held pin cannot wrap it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      clr_cnt_q <= 32'h0;
    else if (clk_en)
    begin
      if (!clr_pin)
        clr_cnt_q <= 32'h0;
      else if (!clr_long)
        clr_cnt_q <= clr_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      sec_cnt_q <= 32'h0;
    else if (clk_en)
      sec_cnt_q <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
  end

  // successive error counters saturate and reset on a good frame
  always_ff @(posedge core_clk)
  begin
    if (rst)
      enc_cnt_q <= 8'h0;
    else if (clk_en)
    begin
      if (cond.enc_comm_ok)
        enc_cnt_q <= 8'h0;
      else if (cond.enc_comm_err && enc_cnt_q != 8'hff)
        enc_cnt_q <= enc_cnt_q + 8'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      scl_cnt_q <= 8'h0;
    else if (clk_en)
    begin
      if (cond.scale_comm_ok)
        scl_cnt_q <= 8'h0;
      else if (cond.scale_comm_err && scl_cnt_q != 8'hff)
        scl_cnt_q <= scl_cnt_q + 8'h1;
    end
  end

  // per warning latch and hold timer
  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++)
    begin : g_warn
      // battery and lifetime never time out
      localparam bit FIXED_INF = (gi == wlc_pkg::W_BATTERY) ||
                                 (gi == wlc_pkg::W_LIFE);
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          warn_q[gi] <= 1'b0;
          hold_left_q[gi] <= 4'h0;
        end
        else if (clk_en)
        begin
          if (clear_any)
          begin
            warn_q[gi] <= 1'b0;
            hold_left_q[gi] <= 4'h0;
          end
          else if (raw[gi])
          begin
            warn_q[gi] <= 1'b1;
            hold_left_q[gi] <= hold_q;
          end
          else if (warn_q[gi] && !FIXED_INF && !infinite && sec_tick)
          begin
            // a partial first second is accepted as the hold granularity
            if (hold_left_q[gi] <= 4'h1)
              warn_q[gi] <= 1'b0;
            else
              hold_left_q[gi] <= hold_left_q[gi] - 4'h1;
          end
          // battery and lifetime fall only through a clear
        end
      end
    end
  endgenerate

  // panel cursor over active warnings
  logic [3:0] next_up;
  logic [3:0] next_dn;
  logic up_edge;
  logic dn_edge;
  assign up_edge = key_sync_q[1][1] & ~key_q[1];
  assign dn_edge = key_sync_q[1][0] & ~key_q[0];

  always_comb
  begin
    next_up = cursor_q;
    next_dn = cursor_q;
    for (int k = NW - 1; k >= 1; k--)
    begin
      if (warn_q[(int'(cursor_q) + k) % NW])
        next_up = 4'((int'(cursor_q) + k) % NW);
      if (warn_q[(int'(cursor_q) + NW - k) % NW])
        next_dn = 4'((int'(cursor_q) + NW - k) % NW);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cursor_q <= 4'h0;
      key_q <= 2'h0;
      panel_code <= 4'h0;
      panel_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      key_q <= key_sync_q[1];
      if (up_edge)
        cursor_q <= next_up;
      else if (dn_edge)
        cursor_q <= next_dn;
      else if (!warn_q[cursor_q])
        cursor_q <= next_up;
      panel_code <= cursor_q;
      panel_valid <= warn_q[cursor_q];
    end
  end

  // wishbone slave, ack one cycle after the request
  logic req;
  logic wr;
  logic [31:0] rd_mux;
  logic [9:0] new_evt;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign new_evt = warn_q & ~warn_active;
  assign rd_mux =
    (wb_adr_i == wlc_pkg::REG_STATUS) ? {22'h0, sticky_q} :
    (wb_adr_i == wlc_pkg::REG_MASK) ? {22'h0, mask_q} :
    (wb_adr_i == wlc_pkg::REG_CONFIG) ? {8'h0, scl_lim_q, enc_lim_q,
                                         4'h0, hold_q} :
    (wb_adr_i == wlc_pkg::REG_ACTIVE) ? {22'h0, warn_q} :
    (wb_adr_i == wlc_pkg::REG_ID) ? ID_VALUE : 32'h0;

  // register write decode
  logic wr_status;
  logic wr_mask;
  logic wr_config;
  logic wr_ctrl;
  assign wr_status = wr && wb_adr_i == wlc_pkg::REG_STATUS;
  assign wr_mask = wr && wb_adr_i == wlc_pkg::REG_MASK;
  assign wr_config = wr && wb_adr_i == wlc_pkg::REG_CONFIG;
  assign wr_ctrl = wr && wb_adr_i == wlc_pkg::REG_CTRL;

  logic [9:0] w1c;
  assign w1c = wr_status ?
               {wb_sel_i[1] ? wb_dat_i[9:8] : 2'h0,
                wb_sel_i[0] ? wb_dat_i[7:0] : 8'h0} : 10'h0;

  logic [3:0] hold_wr;
  assign hold_wr = (wb_dat_i[3:0] > wlc_pkg::HOLD_MAX_S) ?
                   wlc_pkg::HOLD_MAX_S : wb_dat_i[3:0];

  // read data is registered so the output comes straight from a flop
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      wb_dat_q <= 32'h0;
    end
    else if (clk_en)
    begin
      ack_q <= req;
      if (req)
        wb_dat_q <= rd_mux;
    end
  end

  // status, interrupt and the active copy
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sticky_q <= 10'h0;
      warn_active <= 10'h0;
      irq_q <= 1'b0;
    end
    else if (clk_en)
    begin
      // set wins over a write-one clear
      sticky_q <= (sticky_q & ~w1c) | new_evt;
      warn_active <= warn_q;
      irq_q <= |(sticky_q & mask_q);
    end
  end

  // software clear is a one cycle strobe, not a held level
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sw_clear_q <= 1'b0;
    else if (clk_en)
      sw_clear_q <= wr_ctrl && wb_sel_i[0] &&
                    wb_dat_i[wlc_pkg::CTRL_CLEAR_BIT];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      mask_q <= 10'h0;
    else if (clk_en && wr_mask)
    begin
      if (wb_sel_i[0])
        mask_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        mask_q[9:8] <= wb_dat_i[9:8];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hold_q <= wlc_pkg::HOLD_RST;
      enc_lim_q <= wlc_pkg::ENC_LIM_RST;
      scl_lim_q <= wlc_pkg::SCL_LIM_RST;
    end
    else if (clk_en && wr_config)
    begin
      if (wb_sel_i[0])
        hold_q <= hold_wr;
      if (wb_sel_i[1])
        enc_lim_q <= wb_dat_i[15:8];
      if (wb_sel_i[2])
        scl_lim_q <= wb_dat_i[23:16];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = wb_dat_q;
  assign irq = irq_q;
endmodule

// ===== wlc_checker.sv
// concurrent checks on the warning latch ports
`timescale 1ns/1ns
module wlc_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire wlc_pkg::wlc_cond_s cond,
  input wire logic warning_clear_input,
  input wire logic panel_clear_cmd,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [9:0] warn_active
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // the pin synchroniser lags, so raises are judged only after quiet cycles
  wire quiet = !warning_clear_input && !panel_clear_cmd && clk_en;
  sequence s_quiet;
    quiet [*4];
  endsequence
  property p_a0;
    s_quiet ##0 cond.overload_pct_ge |-> ##2 warn_active[0];
  endproperty
  a_a0: assert property (p_a0) else $error("overload warning missing");
  property p_a2;
    s_quiet ##0 cond.batt_low |-> ##2 warn_active[2];
  endproperty
  a_a2: assert property (p_a2) else $error("battery warning missing");
  property p_a5;
    s_quiet ##0 cond.enc_overheat |-> ##2 warn_active[5];
  endproperty
  a_a5: assert property (p_a5) else $error("overheat warning missing");
  property p_a6;
    s_quiet ##0 cond.osc_detect |-> ##2 warn_active[6];
  endproperty
  a_a6: assert property (p_a6) else $error("vibration warning missing");
  property p_a7;
    s_quiet ##0 cond.life_short |-> ##2 warn_active[7];
  endproperty
  a_a7: assert property (p_a7) else $error("lifetime warning missing");
  property p_pin_clear;
    (warning_clear_input && clk_en) [*5] |-> warn_active == 10'h000;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("pin clear");
  property p_panel_clear;
    (panel_clear_cmd && clk_en) [*3] |-> warn_active == 10'h000;
  endproperty
  a_panel_clear: assert property (p_panel_clear) else $error("panel");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one cycle");
endmodule
bind wlc_warning_latch wlc_checker wlc_checker_i (.core_clk(core_clk),
  .rst(rst), .clk_en(clk_en), .cond(cond), .panel_clear_cmd(panel_clear_cmd),
  .warning_clear_input(warning_clear_input), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .warn_active(warn_active));

// ===== wlc_host_model.sv
// host model driving the warning clear pin for a set number of cycles
`timescale 1ns/1ns
module wlc_host_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [15:0] len,
  output logic warning_clear_input
);
  logic [15:0] cnt_q;
  // pin stays off between requests, else every warning is held cleared
  assign warning_clear_input = cnt_q != 16'h0000;
  always_ff @(posedge core_clk)
    if (rst)
      cnt_q <= 16'h0000;
    else if (go)
      cnt_q <= len;
    else if (warning_clear_input)
      cnt_q <= cnt_q - 16'h0001;
endmodule

// ===== tb.sv
// self-checking bench for the warning latch block
`timescale 1ns/1ns
module tb;
  localparam int FAN = 20;
  localparam int SEC = 16;
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, panel_clear_cmd = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
  logic wb_ack_o, panel_valid, irq, warning_clear_input;
  wlc_pkg::wlc_cond_s cond = 12'h000;
  wlc_pkg::wlc_keys_s keys = 2'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic [15:0] len = 16'h0000;
  logic [9:0] warn_active;
  logic [3:0] panel_code;
  int fails = 0, checked = 0;
  wlc_warning_latch #(.FAN_STOP_CYC(FAN), .CLR_MIN_CYC(10), .SEC_CYC(SEC))
    wlc_warning_latch_i (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .cond(cond), .warning_clear_input(warning_clear_input), .keys(keys),
    .panel_clear_cmd(panel_clear_cmd), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .warn_active(warn_active),
    .panel_code(panel_code), .panel_valid(panel_valid), .irq(irq));
  wlc_host_model wlc_host_model_i (.core_clk(core_clk), .rst(rst), .go(go),
    .len(len), .warning_clear_input(warning_clear_input));
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1)
      @(posedge core_clk);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_regs();
    wb(1'b0, wlc_pkg::REG_CONFIG, 32'h0);
    chk(rd, 32'h00030300);
    wb(1'b1, wlc_pkg::REG_CONFIG, 32'h0005040f);
    wb(1'b0, wlc_pkg::REG_CONFIG, 32'h0);
    chk(rd, 32'h0005040a);
    wb(1'b1, wlc_pkg::REG_CONFIG, 32'h00030300);
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_levels();
    int cb[7] = '{11, 10, 9, 5, 4, 3, 2};
    int wn[7] = '{0, 1, 2, 5, 6, 7, 8};
    logic [9:0] e;
    e = 10'h000;
    for (int i = 0; i < 7; i++)
    begin
      cond <= 12'h001 << cb[i];
      tick(4);
      e[wn[i]] = 1'b1;
      chk(warn_active, e);
    end
    cond <= 12'h000;
    chk(irq, 1'b0);
    wb(1'b1, wlc_pkg::REG_MASK, 32'h3ff);
    tick(3);
    chk(irq, 1'b1);
    wb(1'b0, wlc_pkg::REG_STATUS, 32'h0);
    chk(rd, e);
    wb(1'b1, wlc_pkg::REG_STATUS, 32'h3ff);
    tick(3);
    chk(irq, 1'b0);
    go <= 1'b1;
    len <= 16'h0028;
    tick(1);
    go <= 1'b0;
    cond.osc_detect <= 1'b1;
    tick(10);
    chk(warn_active, 10'h000);
    cond <= 12'h000;
    tick(40);
    chk(warn_active, 10'h000);
  endtask
  task automatic t_hold();
    wb(1'b1, wlc_pkg::REG_CONFIG, 32'h00030302);
    cond <= 12'ha18;
    tick(4);
    cond <= 12'h000;
    tick(SEC - 2);
    chk(warn_active, 10'h0c5);
    tick(SEC + 8);
    chk(warn_active, 10'h084);
    // cursor leaves released code 0 for code 2, so steps land on 7 then 2
    for (int i = 0; i < 4; i++)
    begin
      keys <= (i == 3) ? 2'h1 : 2'h2;
      tick(5);
      keys <= 2'h0;
      tick(5);
      chk({panel_valid, panel_code}, (i % 2) ? 5'h12 : 5'h17);
    end
    panel_clear_cmd <= 1'b1;
    tick(3);
    panel_clear_cmd <= 1'b0;
    tick(3);
    chk(warn_active, 10'h000);
  endtask
  task automatic t_comm(input int eb, input int ob, input int wn);
    for (int i = 0; i < 8; i++)
    begin
      cond <= 12'h001 << ((i == 3) ? ob : eb);
      tick(1);
      cond <= 12'h000;
      tick(3);
      if (i == 6)
        chk(warn_active[wn], 1'b0);
    end
    chk(warn_active[wn], 1'b1);
    // a good frame zeroes the count, else the clear is undone at once
    cond <= 12'h001 << ob;
    tick(1);
    cond <= 12'h000;
    wb(1'b1, wlc_pkg::REG_CTRL, 32'h1);
    tick(2);
    chk(warn_active, 10'h000);
  endtask
  task automatic t_fan();
    cond.fan_stopped <= 1'b1;
    tick(FAN - 3);
    cond <= 12'h000;
    tick(4);
    chk(warn_active[3], 1'b0);
    cond.fan_stopped <= 1'b1;
    tick(FAN + 6);
    chk(warn_active[3], 1'b1);
    cond <= 12'h000;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    complete_run();
  end
  initial
  begin
    tick(16);
    rst <= 1'b0;
    tick(1);
    t_regs();
    t_levels();
    t_hold();
    t_comm(7, 6, 4);
    t_comm(1, 0, 9);
    t_fan();
    complete_run();
  end
endmodule
